//--- verification/iit_timer_test.sv
`timescale 1ns/1ps
module iit_timer_test
    import iit_pkg::*;
;
    // ****************************************
    // Signals
    // ****************************************
    typedef struct {
        string       what;
        logic [31:0] exp;
        int          tol;
    } iit_note_s;

    logic             clk   = 1'b0;
    logic             rst   = 1'b1;
    logic             cyc   = 1'b0;
    logic             stb   = 1'b0;
    logic             we    = 1'b0;
    logic [ADR_W-1:0] adr   = 8'h00;
    logic [SEL_W-1:0] sel   = 4'hF;
    logic [DAT_W-1:0] datW  = 32'h0000_0000;
    logic [DAT_W-1:0] datR;
    logic             ack;
    logic             irq;
    logic [15:0]      vec;
    iit_note_s        notes[$];
    iit_note_s        cur;
    int               seed  = 50;
    int               cycles = 0;
    int               irqCount = 0;
    int               lastIrq = 0;
    int               num_errors = 0;
    int               total_checks = 0;

    always #2.5 clk = ~clk;

    iit_timer dut_u (
        .clk       (clk),
        .rst       (rst),
        .cyc_i     (cyc),
        .stb_i     (stb),
        .we_i      (we),
        .adr_i     (adr),
        .sel_i     (sel),
        .dat_i     (datW),
        .dat_o     (datR),
        .ack_o     (ack),
        .timerIrq  (irq),
        .irqVector (vec)
    );

    // ****************************************
    // Checking and bus tasks
    // ****************************************
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp, input int tol);
        logic bad;
        total_checks++;
        if (tol == 0) bad = (seen !== exp);
        else bad = (^seen === 1'bx) || (seen > exp + tol) || (seen + tol < exp);
        if (bad) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        int n;
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        datW <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1);
        check("ack latency", n, 32'h0000_0002, 0);
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rd(input string what, input logic [7:0] a,
                      input logic [31:0] exp, input int tol);
        notes.push_back('{what, exp, tol});
        xfer(1'b0, a, $random(seed));
    endtask

    function automatic logic [31:0] ctl(int code, bit en, bit rel, bit off);
        return {25'h000_0000, off, rel, en, code[3:0]};
    endfunction

    task automatic waitIrq(input int base, input int lim);
        int n;
        n = 0;
        while (irqCount == base && n < lim) begin
            @(posedge clk);
            n++;
        end
    endtask

    task automatic pauseTest(input logic [7:0] a, input logic [31:0] offV,
                             input logic [31:0] onV);
        int base;
        int t0;
        wr(a, offV);
        rd("status off", OFS_STATUS, 32'h0000_0001, 0);
        base = irqCount;
        repeat (100) @(posedge clk);
        check("irq while off", irqCount, base, 0);
        wr(a, onV);
        base = irqCount;
        t0 = cycles;
        repeat (80) @(posedge clk);
        check("irq resumed", irqCount - base, (cycles - t0) / 8, 2);
    endtask

    // ****************************************
    // Result monitor
    // ****************************************
    always @(posedge clk) begin
        cycles++;
        if (ack === 1'b1 && we === 1'b0 && notes.size() > 0) begin
            cur = notes.pop_front();
            check(cur.what, datR, cur.exp, cur.tol);
        end
        if (irq === 1'b1) begin
            irqCount++;
            lastIrq = cycles;
        end
    end

    initial begin
        #300000;
        num_errors++;
        test_done();
    end

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        int p;
        int base;
        int t0;
        int exp;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        check("vector", {16'h0000, vec}, 32'h0000_0010, 0);
        rd("ctrl reset", OFS_CTRL, 32'h0000_0000, 0);
        rd("count reset", OFS_PERIOD, 32'h0000_0000, 0);
        rd("unmapped", 8'h20, 32'h0000_0000, 0);
        check("irq after reset", irqCount, 0, 0);
        for (int i = 0; i < 4; i++) begin
            p = $random(seed) & 32'h0000_FFFF;
            wr(OFS_PERIOD, p);
            rd("loaded count", OFS_PERIOD, p, 0);
        end
        repeat (40) @(posedge clk);
        rd("held count", OFS_PERIOD, p, 0);
        wr(OFS_INT_EN, 32'h0000_0100);
        wr(OFS_PERIOD, 32'h0000_0100);
        wr(OFS_CTRL, ctl(2, 1, 0, 0));
        t0 = cycles;
        repeat (80) @(posedge clk);
        wr(OFS_CTRL, ctl(2, 0, 0, 0));
        exp = 256 - (cycles - t0) / 8;
        rd("live count", OFS_PERIOD, exp, 2);
        repeat (40) @(posedge clk);
        rd("stopped count", OFS_PERIOD, exp, 2);
        for (int c = 0; c < 12; c++) begin
            p = 2 << c;
            wr(OFS_CTRL, ctl(c, 1, 0, 0));
            base = irqCount;
            wr(OFS_PERIOD, 32'h0000_0004);
            t0 = cycles;
            waitIrq(base, 5 * p + 50);
            check("irq delay", lastIrq - t0, 7 * p / 2 + 1, p / 2 + 3);
            repeat (c < 3 ? 3 * p : 4) @(posedge clk);
            check("one shot", irqCount, base + 1, 0);
            rd("idle count", OFS_PERIOD, 32'h0000_0000, 0);
        end
        wr(OFS_CTRL, ctl(0, 1, 1, 0));
        wr(OFS_PERIOD, 32'h0000_0004);
        base = irqCount;
        t0 = cycles;
        repeat (200) @(posedge clk);
        check("repeat irqs", irqCount - base, (cycles - t0) / 8, 1);
        pauseTest(OFS_CTRL, ctl(0, 1, 1, 1), ctl(0, 1, 1, 0));
        pauseTest(OFS_POWER, 32'h0000_0010, 32'h0000_0000);
        wr(OFS_INT_EN, 32'h0000_0000);
        repeat (2) @(posedge clk);
        base = irqCount;
        repeat (100) @(posedge clk);
        check("irq masked", irqCount, base, 0);
        wr(OFS_INT_EN, 32'h0000_0100);
        base = irqCount;
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (100) @(posedge clk);
        check("irq over reset", irqCount, base, 0);
        rd("ctrl rerst", OFS_CTRL, 32'h0000_0000, 0);
        rd("count rerst", OFS_PERIOD, 32'h0000_0000, 0);
        wr(OFS_CTRL, ctl(15, 1, 0, 0));
        wr(OFS_PERIOD, 32'h0000_0003);
        repeat (300) @(posedge clk);
        rd("slow count", OFS_PERIOD, 32'h0000_0003, 1);
        repeat (4) @(posedge clk);
        test_done();
    end
endmodule

//--- verilog/iit_pkg.sv
package iit_pkg;

    // ****************************************
    // Bus geometry
    // ****************************************
    localparam int          ADR_W          = 8;
    localparam int          DAT_W          = 32;
    localparam int          SEL_W          = 4;

    // ****************************************
    // Register offsets (byte addresses)
    // ****************************************
    localparam logic [7:0]  OFS_CTRL       = 8'h00;
    localparam logic [7:0]  OFS_PERIOD     = 8'h04;
    localparam logic [7:0]  OFS_INT_EN     = 8'h08;
    localparam logic [7:0]  OFS_POWER      = 8'h0C;
    localparam logic [7:0]  OFS_STATUS     = 8'h10;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int          CNT_W          = 16;
    localparam int          DIV_SEL_LSB    = 0;
    localparam int          DIV_SEL_W      = 4;
    localparam int          CTRL_EN_BIT    = 4;
    localparam int          CTRL_RELOAD_BIT = 5;
    localparam int          CTRL_OFF_BIT   = 6;
    localparam int          CTRL_W         = 7;
    localparam int          INT_EN_BIT     = 8;
    localparam int          POWER_OFF_BIT  = 4;
    localparam int          STAT_ACTIVE_BIT = 0;
    localparam int          STAT_RUN_BIT   = 1;

    // ****************************************
    // Reset values and vector
    // ****************************************
    localparam logic [6:0]  CTRL_RST       = 7'h00;
    localparam logic [15:0] CNT_RST        = 16'h0000;
    localparam logic [15:0] IRQ_VECTOR     = 16'h0010;
    localparam logic [31:0] DAT_ZERO       = 32'h0000_0000;

    // ****************************************
    // Timing
    // ****************************************
    localparam int          CLK_PERIOD_PS  = 5000;
    localparam int          PRESC_W        = 16;

endpackage

//--- verilog/iit_prescaler.sv
`timescale 1ns/1ps
module iit_prescaler
    import iit_pkg::*;
#(
    parameter int W = PRESC_W
) (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 run,
    input  wire logic [DIV_SEL_W-1:0] divSel,
    output logic                      tick
);

    // ****************************************
    // Binary divider
    // ****************************************
    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;
    logic [W-1:0] lowMask;
    logic [DIV_SEL_W:0] shiftAmt;
    wire          allOnes;

    // Code n ticks once every 2^(n+1) clocks
    // Shift amount one bit wider so the top code does not wrap to zero
    assign shiftAmt = {1'b0, divSel} + 1'b1;
    assign lowMask = W'(({{(W-1){1'b0}}, 1'b1} << shiftAmt) - 1'b1);
    assign allOnes = &(cnt_r | ~lowMask);                    // R12 R15
    assign cnt_nxt = run ? W'(cnt_r + 1'b1) : '0;            // R13 R14
    assign tick    = run & allOnes;

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

endmodule

//--- verilog/iit_timer.sv
`timescale 1ns/1ps
// Functional notes
// R01 - Sixteen-bit loadable counter decrements per prescaled tick
// R02 - Zero count fires vector 0x10 if enabled
// R03 - One-shot: interrupt once, then idle until rewritten
// R04 - Period write loads counter and holding register
// R05 - Auto-repeat reloads from holding register forever
// R06 - Live count readable; period writable anytime
// R07 - Stop or restart may lose one tick
// R08 - Reset clears control low bits and counter
// R09 - Reset never produces a timer interrupt
// R10 - Holding register survives reset
// R11 - Count enable gates decrementing; else hold
// R12 - Divide select picks one of sixteen rates
// R13 - Control shutdown bit stops timer and prescaler
// R14 - Power register bit 4 also shuts down
// R15 - Code zero halves clock; each code doubles
// R16 - Period register reads return live count
module iit_timer
    import iit_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             cyc_i,
    input  wire logic             stb_i,
    input  wire logic             we_i,
    input  wire logic [ADR_W-1:0] adr_i,
    input  wire logic [SEL_W-1:0] sel_i,
    input  wire logic [DAT_W-1:0] dat_i,
    output logic      [DAT_W-1:0] dat_o,
    output logic                  ack_o,
    output logic                  timerIrq,
    output logic      [15:0]      irqVector
);

    // ****************************************
    // Byte lane merge
    // ****************************************
    function automatic logic [DAT_W-1:0] laneMerge(
        input logic [DAT_W-1:0] oldVal,
        input logic [DAT_W-1:0] newVal,
        input logic [SEL_W-1:0] sel
    );
        logic [DAT_W-1:0] res;
        res = oldVal;
        for (int i = 0; i < SEL_W; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = newVal[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // ****************************************
    // Declarations
    // ****************************************
    logic             ack_r;
    logic [DAT_W-1:0] datOut_r;
    logic [CTRL_W-1:0] ctrl_r;
    logic [CTRL_W-1:0] ctrl_nxt;
    logic             intEn_r;
    logic             intEn_nxt;
    logic             powerOff_r;
    logic             powerOff_nxt;
    logic [CNT_W-1:0] counter_r;
    logic [CNT_W-1:0] counter_nxt;
    logic [CNT_W-1:0] period_r;
    logic [CNT_W-1:0] period_nxt;
    logic             active_r;
    logic             active_nxt;
    logic             irq_r;
    logic [DAT_W-1:0] readMux;
    logic [DAT_W-1:0] ctrlMerged;
    logic [DAT_W-1:0] intMerged;
    logic [DAT_W-1:0] powerMerged;
    logic [DAT_W-1:0] periodMerged;

    wire              busReq;
    wire              wrStrobe;
    wire              selCtrl;
    wire              selPeriod;
    wire              selIntEn;
    wire              selPower;
    wire              selStatus;
    wire              wrCtrl;
    wire              wrPeriod;
    wire              wrIntEn;
    wire              wrPower;
    wire              ctrlOff;
    wire              countEn;
    wire              reloadEn;
    wire              timerRun;
    wire              tick;
    wire              stepEvent;
    wire              zeroEvent;
    wire [DIV_SEL_W-1:0] divSel;

    // ****************************************
    // Wishbone decode
    // ****************************************
    assign busReq    = cyc_i & stb_i;
    assign wrStrobe  = busReq & we_i & ack_r;
    assign selCtrl   = (adr_i == OFS_CTRL);
    assign selPeriod = (adr_i == OFS_PERIOD);
    assign selIntEn  = (adr_i == OFS_INT_EN);
    assign selPower  = (adr_i == OFS_POWER);
    assign selStatus = (adr_i == OFS_STATUS);
    assign wrCtrl    = wrStrobe & selCtrl;
    assign wrPeriod  = wrStrobe & selPeriod;                   // R06
    assign wrIntEn   = wrStrobe & selIntEn;
    assign wrPower   = wrStrobe & selPower;

    assign ctrlMerged   = laneMerge({{(DAT_W-CTRL_W){1'b0}}, ctrl_r},
                                    dat_i, sel_i);
    assign intMerged    = laneMerge(DAT_ZERO | (DAT_W'(intEn_r)
                                    << INT_EN_BIT), dat_i, sel_i);
    assign powerMerged  = laneMerge(DAT_ZERO | (DAT_W'(powerOff_r)
                                    << POWER_OFF_BIT), dat_i, sel_i);
    assign periodMerged = laneMerge({{(DAT_W-CNT_W){1'b0}}, counter_r},
                                    dat_i, sel_i);

    // ****************************************
    // Read mux
    // ****************************************
    always_comb begin
        readMux = DAT_ZERO;
        if (selCtrl) begin
            readMux[CTRL_W-1:0] = ctrl_r;
        end else if (selPeriod) begin
            readMux[CNT_W-1:0] = counter_r;                    // R16
        end else if (selIntEn) begin
            readMux[INT_EN_BIT] = intEn_r;
        end else if (selPower) begin
            readMux[POWER_OFF_BIT] = powerOff_r;
        end else if (selStatus) begin
            readMux[STAT_ACTIVE_BIT] = active_r;
            readMux[STAT_RUN_BIT]    = timerRun;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ack_r    <= 1'b0;
            datOut_r <= DAT_ZERO;
        end else begin
            ack_r    <= busReq & ~ack_r;
            datOut_r <= (busReq & ~ack_r & ~we_i) ? readMux : datOut_r;
        end
    end

    assign ack_o = ack_r;
    assign dat_o = datOut_r;

    // ****************************************
    // Control registers
    // ****************************************
    assign ctrl_nxt     = wrCtrl ? ctrlMerged[CTRL_W-1:0] : ctrl_r;
    assign intEn_nxt    = wrIntEn ? intMerged[INT_EN_BIT] : intEn_r;
    assign powerOff_nxt = wrPower ? powerMerged[POWER_OFF_BIT]
                                  : powerOff_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_r     <= CTRL_RST;                            // R08
            intEn_r    <= 1'b0;
            powerOff_r <= 1'b0;
        end else begin
            ctrl_r     <= ctrl_nxt;
            intEn_r    <= intEn_nxt;
            powerOff_r <= powerOff_nxt;
        end
    end

    assign divSel   = ctrl_r[DIV_SEL_LSB +: DIV_SEL_W];
    assign countEn  = ctrl_r[CTRL_EN_BIT];
    assign reloadEn = ctrl_r[CTRL_RELOAD_BIT];
    assign ctrlOff  = ctrl_r[CTRL_OFF_BIT];
    assign timerRun = ~ctrlOff & ~powerOff_r;                  // R13 R14

    // ****************************************
    // Prescaler
    // ****************************************
    iit_prescaler #(
        .W      (PRESC_W)
    ) uPresc (
        .clk    (clk),
        .rst    (rst),
        .run    (timerRun),
        .divSel (divSel),
        .tick   (tick)
    );

    // ****************************************
    // Down counter
    // ****************************************
    assign stepEvent = tick & timerRun & countEn & active_r
                     & ~wrPeriod;                              // R11 R07
    assign zeroEvent = stepEvent & (counter_r == CNT_W'(1));

    always_comb begin
        counter_nxt = counter_r;
        period_nxt  = period_r;
        active_nxt  = active_r;
        if (wrPeriod) begin
            counter_nxt = periodMerged[CNT_W-1:0];             // R04
            period_nxt  = periodMerged[CNT_W-1:0];
            active_nxt  = (periodMerged[CNT_W-1:0] != CNT_RST);
        end else if (zeroEvent) begin
            if (reloadEn) begin
                counter_nxt = period_r;                        // R05
            end else begin
                counter_nxt = CNT_RST;                         // R03
                active_nxt  = 1'b0;
            end
        end else if (stepEvent) begin
            counter_nxt = CNT_W'(counter_r - 1'b1);            // R01
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            counter_r <= CNT_RST;                              // R08
            active_r  <= 1'b0;
        end else begin
            counter_r <= counter_nxt;
            active_r  <= active_nxt;
        end
    end

    // Holding register has no reset
    always_ff @(posedge clk) begin
        period_r <= period_nxt;                                // R10
    end

    // ****************************************
    // Interrupt request
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_r <= 1'b0;                                     // R09
        end else begin
            irq_r <= zeroEvent & intEn_r;                      // R02
        end
    end

    assign timerIrq  = irq_r;
    assign irqVector = IRQ_VECTOR;                             // R02

    // ****************************************
    // Assertions
    // ****************************************
    a_reset_no_irq: assert property (                          // R09
        @(posedge clk) rst |=> !timerIrq
    ) else $error("Timer interrupt raised by reset");

    a_reset_clears: assert property (                          // R08
        @(posedge clk) rst |=> (counter_r == CNT_RST) && !active_r
            && (ctrl_r[5:0] == 6'h00)
    ) else $error("Reset did not clear timer state");

    a_write_loads: assert property (                           // R04
        @(posedge clk) disable iff (rst)
        wrPeriod && (sel_i[1:0] == 2'b11)
        |=> (counter_r == $past(dat_i[15:0]))
            && (period_r == $past(dat_i[15:0]))
    ) else $error("Period write did not load both registers");

    a_count_step: assert property (                            // R01
        @(posedge clk) disable iff (rst)
        stepEvent && (counter_r > CNT_W'(1))
        |=> counter_r == CNT_W'($past(counter_r) - 1'b1)
    ) else $error("Counter did not decrement by one");

    a_hold_disabled: assert property (                         // R11
        @(posedge clk) disable iff (rst)
        !countEn && !wrPeriod |=> $stable(counter_r)
    ) else $error("Counter moved while count disabled");

    a_irq_gated: assert property (                             // R02
        @(posedge clk) disable iff (rst)
        zeroEvent |=> (timerIrq == $past(intEn_r))
            && (irqVector == 16'h0010)
    ) else $error("Interrupt not gated by enable");

    a_oneshot_stop: assert property (                          // R03
        @(posedge clk) disable iff (rst)
        zeroEvent && !reloadEn
        |=> !active_r && (counter_r == CNT_RST)
            ##1 (!active_r || $past(wrPeriod))
    ) else $error("One-shot timer did not stop");

    a_auto_reload: assert property (                           // R05
        @(posedge clk) disable iff (rst)
        zeroEvent && reloadEn
        |=> (counter_r == $past(period_r)) && active_r
    ) else $error("Auto-repeat did not reload");

    a_shutdown_stop: assert property (                         // R13 R14
        @(posedge clk) disable iff (rst)
        (ctrlOff || powerOff_r) && !wrPeriod
        |-> !tick ##1 $stable(counter_r)
    ) else $error("Timer ran while shut down");

endmodule
